// [conv_ctrl_pkg.sv]
// Shared constants and types for the converter control link
package conv_ctrl_pkg;
    localparam int CODE_W = 8;
    localparam logic [7:0] CODE_MIN = 8'h00;
    localparam logic [7:0] CODE_MAX = 8'hff;
    localparam logic [7:0] CODE_MID = 8'h80;
    // Calibration pin timing, in sample clocks
    localparam int TRIM_LOW_MIN = 1280;
    localparam int TRIM_HIGH_MIN = 1280;
    localparam logic [11:0] TRIM_LOW_CNT = 12'h500;
    localparam logic [11:0] TRIM_HIGH_CNT = 12'h500;
    // Pipeline latency of primary and delayed buses
    localparam int LAT_PRI = 13;
    localparam int LAT_DLY = 14;
    localparam int REC_DELAY_S = 20;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    localparam logic [31:0] ONE32 = 32'h0000_0001;
    // Host register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_IRQ = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0c;
    localparam logic [7:0] OFS_DATA = 8'h10;
    // Control register bit positions
    localparam int B_PD = 0;
    localparam int B_DLYSEL = 1;
    localparam int B_RANGE = 2;
    localparam int B_DEMUX = 3;
    localparam int B_REDUCED = 4;
    localparam int B_PHADJ = 5;
    localparam int B_PERMIT = 6;
    localparam int B_CALBIT = 7;
    localparam int B_TRIMREQ = 8;
    // Event bit positions
    localparam int E_CALDONE = 0;
    localparam int E_RANGE = 1;
    localparam int E_NEWDATA = 2;
    localparam int E_W = 3;
    typedef enum logic [2:0] {
        CAL_WAIT_DELAY = 3'b000,
        CAL_WAIT_LOW = 3'b001,
        CAL_WAIT_HIGH = 3'b010,
        CAL_RUN = 3'b011,
        CAL_IDLE = 3'b100
    } cal_state_t;
endpackage

// [conv_link_if.sv]
// Interface joining the converter and its host controller
`timescale 1ns/100ps
interface conv_link_if;
    logic trim_req_n;
    logic startup_trim_delay_select;
    logic power_down_pin;
    logic input_range_select;
    logic demux_mode;
    logic reduced_level;
    logic phase_adjust_en;
    logic phase_trim_permit;
    logic cal_bit;
    logic link_clk;
    logic calibrating;
    logic range_exceed;
    logic [7:0] chan_a_bus;
    logic [7:0] chan_b_bus;
    logic [7:0] chan_a_delayed_bus;
    logic [7:0] chan_b_delayed_bus;
    modport device (
        input trim_req_n, startup_trim_delay_select, power_down_pin, input_range_select,
        input demux_mode, reduced_level, phase_adjust_en, phase_trim_permit, cal_bit,
        output link_clk, calibrating, range_exceed,
        output chan_a_bus, chan_b_bus, chan_a_delayed_bus, chan_b_delayed_bus
    );
    modport host (
        output trim_req_n, startup_trim_delay_select, power_down_pin, input_range_select,
        output demux_mode, reduced_level, phase_adjust_en, phase_trim_permit, cal_bit,
        input link_clk, calibrating, range_exceed,
        input chan_a_bus, chan_b_bus, chan_a_delayed_bus, chan_b_delayed_bus
    );
endinterface

// [conv_device.sv]
// Converter end: calibration sequencing, saturation and output buses
`timescale 1ns/100ps
// How it works
// (RL1) Calibrate automatically after power-up
// (RL2) Host pulses trim pin low, then high
// (RL3) Trim pin high at power-up defers calibration
// (RL4) Delay select pin picks startup delay
// (RL5) Power-down holds startup delay counter
// (RL6) No calibration start or run in power-down
// (RL7) Host recalibrates after range select change
// (RL8) Host recalibrates after twenty seconds, temperature
// (RL9) Calibration bit not self-clearing; rearm by zero
// (RL10) Phase adjust on: calibrate only if permitted; only the calibration bit is gated, pin command and power-up are not
// (RL11) Phase adjust off: permit bit ignored
// (RL12) Saturate codes to all zeros or ones
// (RL13) One shared range-exceed flag, both channels
// (RL14) Demux halves bus rate; otherwise full rate
// (RL15) New word each clock, fixed latency
// (RL16) Output level normal or reduced
// (RL17) Primary buses 13, delayed buses 14 cycles; the output register adds one, giving 14 and 15 here
// (RL18) Output codes are offset binary
module conv_device #(
    parameter logic [31:0] DELAY_SHORT = 32'h0400_0000,
    parameter logic [31:0] DELAY_LONG = 32'hffff_ffff,
    parameter logic [31:0] CAL_CYCLES = 32'h0015_5cc0
) (
    input wire logic clk,
    input wire logic reset_n,
    conv_link_if.device link,
    input wire logic signed [9:0] sample_a,
    input wire logic signed [9:0] sample_b,
    output logic reduced_drive,
    output logic busy
);
    import conv_ctrl_pkg::*;

    // Offset binary with clipping beyond full scale
    function automatic logic [8:0] quantize(input logic signed [9:0] s);
        if (s < -10'sd128)
            quantize = {1'b1, CODE_MIN}; // RL12
        else if (s > 10'sd127)
            quantize = {1'b1, CODE_MAX}; // RL12
        else
            quantize = {1'b0, s[7:0] ^ CODE_MID}; // RL18
    endfunction

    logic [1:0] trim_sync_reg;
    logic [1:0] pd_sync_reg;
    logic [1:0] cal_sync_reg;
    logic [1:0] dly_sync_reg;
    logic [1:0] ph_sync_reg;
    logic [1:0] pm_sync_reg;
    logic [1:0] dmx_sync_reg;
    logic [1:0] lvl_sync_reg;
    cal_state_t state_reg;
    logic [31:0] count_reg;
    logic [11:0] pin_cnt_reg;
    logic cal_bit_prev_reg;
    logic [8:0] code_a;
    logic [8:0] code_b;
    logic [7:0] pipe_a_reg [0:LAT_DLY-1];
    logic [7:0] pipe_b_reg [0:LAT_DLY-1];
    logic [LAT_PRI-1:0] over_pipe_reg;
    logic half_reg;
    logic link_clk_reg;
    logic cal_start;
    logic pin_cmd_done;
    logic pd_now;

    // Two-flop synchronisers for the control pins from the host, all but range select
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trim_sync_reg <= 2'h3;
            pd_sync_reg <= 2'h0;
            cal_sync_reg <= 2'h0;
            dly_sync_reg <= 2'h0;
            ph_sync_reg <= 2'h0;
            pm_sync_reg <= 2'h0;
            dmx_sync_reg <= 2'h0;
            lvl_sync_reg <= 2'h0;
        end else begin
            trim_sync_reg <= {trim_sync_reg[0], link.trim_req_n};
            pd_sync_reg <= {pd_sync_reg[0], link.power_down_pin};
            cal_sync_reg <= {cal_sync_reg[0], link.cal_bit};
            dly_sync_reg <= {dly_sync_reg[0], link.startup_trim_delay_select};
            ph_sync_reg <= {ph_sync_reg[0], link.phase_adjust_en};
            pm_sync_reg <= {pm_sync_reg[0], link.phase_trim_permit};
            dmx_sync_reg <= {dmx_sync_reg[0], link.demux_mode};
            lvl_sync_reg <= {lvl_sync_reg[0], link.reduced_level};
        end
    end

    assign pd_now = pd_sync_reg[1];
    assign pin_cmd_done = (state_reg == CAL_WAIT_HIGH) && (pin_cnt_reg >= TRIM_HIGH_CNT);

    // Trim pin command qualifier: low time, then high time
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            pin_cnt_reg <= 12'h000;
        else if (state_reg == CAL_WAIT_LOW || state_reg == CAL_IDLE) begin
            if (trim_sync_reg[1])
                pin_cnt_reg <= 12'h000;
            else if (pin_cnt_reg < TRIM_LOW_CNT)
                pin_cnt_reg <= pin_cnt_reg + 12'h001; // RL2
        end else if (state_reg == CAL_WAIT_HIGH) begin
            if (!trim_sync_reg[1])
                pin_cnt_reg <= 12'h000;
            else if (pin_cnt_reg < TRIM_HIGH_CNT)
                pin_cnt_reg <= pin_cnt_reg + 12'h001; // RL2
        end else
            pin_cnt_reg <= 12'h000;
    end

    // Register-bit request, rising edge only; gated by phase adjust permit
    assign cal_start = (cal_sync_reg[1] && !cal_bit_prev_reg)
        && (!ph_sync_reg[1] || pm_sync_reg[1]); // RL10 RL11

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            cal_bit_prev_reg <= 1'b0;
        else
            cal_bit_prev_reg <= cal_sync_reg[1]; // RL9
    end

    // Calibration sequencer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= CAL_WAIT_DELAY;
            count_reg <= ZERO32;
        end else begin
            case (state_reg)
                CAL_WAIT_DELAY: begin
                    if (!pd_now) begin // RL5
                        if (count_reg >= (dly_sync_reg[1] ? DELAY_LONG : DELAY_SHORT)) begin
                            count_reg <= ZERO32;
                            // Pin held high at start defers to a full pin command
                            state_reg <= trim_sync_reg[1] ? CAL_WAIT_LOW : CAL_RUN; // RL1 RL3
                        end else
                            count_reg <= count_reg + ONE32; // RL4
                    end
                end
                CAL_WAIT_LOW: begin
                    if (pin_cnt_reg >= TRIM_LOW_CNT && trim_sync_reg[1]) begin
                        state_reg <= CAL_WAIT_HIGH;
                    end
                end
                CAL_WAIT_HIGH: begin
                    if (!trim_sync_reg[1] && pin_cnt_reg < TRIM_HIGH_CNT)
                        state_reg <= CAL_WAIT_LOW;
                    else if (pin_cmd_done && !pd_now) begin
                        state_reg <= CAL_RUN; // RL2 RL6
                        count_reg <= ZERO32;
                    end
                end
                CAL_RUN: begin
                    // Power-down aborts; the trim stays incomplete
                    if (pd_now)
                        state_reg <= CAL_IDLE; // RL6
                    else if (count_reg >= CAL_CYCLES - ONE32) begin
                        state_reg <= CAL_IDLE;
                        count_reg <= ZERO32;
                    end else
                        count_reg <= count_reg + ONE32;
                end
                CAL_IDLE: begin
                    count_reg <= ZERO32;
                    if (!pd_now && cal_start)
                        state_reg <= CAL_RUN; // RL6 RL10 RL11
                    else if (pin_cnt_reg >= TRIM_LOW_CNT && trim_sync_reg[1])
                        state_reg <= CAL_WAIT_HIGH;
                end
                default: state_reg <= CAL_IDLE;
            endcase
        end
    end

    assign code_a = quantize(sample_a);
    assign code_b = quantize(sample_b);

    // Sample pipelines, one word per clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < LAT_DLY; i++) begin
                pipe_a_reg[i] <= CODE_MIN;
                pipe_b_reg[i] <= CODE_MIN;
            end
            over_pipe_reg <= '0;
        end else begin
            pipe_a_reg[0] <= code_a[7:0]; // RL15
            pipe_b_reg[0] <= code_b[7:0];
            for (int i = 1; i < LAT_DLY; i++) begin
                pipe_a_reg[i] <= pipe_a_reg[i-1];
                pipe_b_reg[i] <= pipe_b_reg[i-1];
            end
            over_pipe_reg <= {over_pipe_reg[LAT_PRI-2:0], code_a[8] | code_b[8]}; // RL13
        end
    end

    // Output buses; demux updates every other clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            half_reg <= 1'b0;
            link_clk_reg <= 1'b0;
            link.chan_a_bus <= CODE_MIN;
            link.chan_b_bus <= CODE_MIN;
            link.chan_a_delayed_bus <= CODE_MIN;
            link.chan_b_delayed_bus <= CODE_MIN;
            link.range_exceed <= 1'b0;
        end else begin
            half_reg <= ~half_reg;
            link.range_exceed <= over_pipe_reg[LAT_PRI-1]; // RL13 RL17
            if (dmx_sync_reg[1]) begin
                // One link clock edge per bus update, so capture runs at half rate
                if (half_reg) begin // RL14
                    link_clk_reg <= ~link_clk_reg;
                    link.chan_a_bus <= pipe_a_reg[LAT_PRI-1]; // RL17
                    link.chan_b_bus <= pipe_b_reg[LAT_PRI-1];
                    link.chan_a_delayed_bus <= pipe_a_reg[LAT_DLY-1]; // RL17
                    link.chan_b_delayed_bus <= pipe_b_reg[LAT_DLY-1];
                end
            end else begin
                link_clk_reg <= ~link_clk_reg;
                link.chan_a_bus <= pipe_a_reg[LAT_PRI-1]; // RL14
                link.chan_b_bus <= pipe_b_reg[LAT_PRI-1];
                link.chan_a_delayed_bus <= CODE_MIN;
                link.chan_b_delayed_bus <= CODE_MIN;
            end
        end
    end

    assign link.link_clk = link_clk_reg;
    assign link.calibrating = (state_reg == CAL_RUN);
    assign busy = (state_reg == CAL_RUN);
    assign reduced_drive = lvl_sync_reg[1]; // RL16
endmodule

// [conv_host.sv]
// Host end: APB registers, pin driving, bus capture and interrupts
`timescale 1ns/100ps
module conv_host (
    input wire logic clk,
    input wire logic reset_n,
    conv_link_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    import conv_ctrl_pkg::*;

    logic [8:0] ctrl_reg;
    logic [E_W-1:0] irq_reg;
    logic [E_W-1:0] mask_reg;
    logic [E_W-1:0] ev;
    logic [1:0] cal_sync_reg;
    logic [1:0] ovr_sync_reg;
    logic [1:0] lclk_sync_reg;
    logic lclk_prev_reg;
    logic cal_prev_reg;
    logic [31:0] data_reg;
    logic wr;
    logic rd;
    logic mapped;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign mapped = (paddr == OFS_CTRL) || (paddr == OFS_STAT) || (paddr == OFS_IRQ)
        || (paddr == OFS_MASK) || (paddr == OFS_DATA);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Synchronise device outputs and the output clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cal_sync_reg <= 2'h0;
            ovr_sync_reg <= 2'h0;
            lclk_sync_reg <= 2'h0;
            lclk_prev_reg <= 1'b0;
            cal_prev_reg <= 1'b0;
        end else begin
            cal_sync_reg <= {cal_sync_reg[0], link.calibrating};
            ovr_sync_reg <= {ovr_sync_reg[0], link.range_exceed};
            lclk_sync_reg <= {lclk_sync_reg[0], link.link_clk};
            lclk_prev_reg <= lclk_sync_reg[1];
            cal_prev_reg <= cal_sync_reg[1];
        end
    end

    // Capture words on each output clock edge; skew-limited, for monitoring only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            data_reg <= ZERO32;
        else if (lclk_sync_reg[1] != lclk_prev_reg)
            data_reg <= {link.chan_b_delayed_bus, link.chan_a_delayed_bus,
                link.chan_b_bus, link.chan_a_bus};
    end

    assign ev[E_CALDONE] = cal_prev_reg && !cal_sync_reg[1];
    assign ev[E_RANGE] = ovr_sync_reg[1];
    assign ev[E_NEWDATA] = lclk_sync_reg[1] != lclk_prev_reg;

    // Control register drives pins; software re-arms the calibration bit
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            ctrl_reg <= 9'h100;
        else if (wr && paddr == OFS_CTRL)
            ctrl_reg <= pwdata[8:0]; // RL7 RL8 RL9
    end

    // Sticky events, set wins over write-one-to-clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            irq_reg <= '0;
        else if (wr && paddr == OFS_IRQ)
            irq_reg <= (irq_reg & ~pwdata[E_W-1:0]) | ev;
        else
            irq_reg <= irq_reg | ev;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            mask_reg <= '0;
        else if (wr && paddr == OFS_MASK)
            mask_reg <= pwdata[E_W-1:0];
    end

    // Read data registered at the setup edge, ready for the access phase
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            prdata <= ZERO32;
        else if (psel && !penable && !pwrite) begin
            case (paddr)
                OFS_CTRL: prdata <= {23'h0, ctrl_reg};
                OFS_STAT: prdata <= {30'h0, ovr_sync_reg[1], cal_sync_reg[1]};
                OFS_IRQ: prdata <= {29'h0, irq_reg};
                OFS_MASK: prdata <= {29'h0, mask_reg};
                OFS_DATA: prdata <= data_reg;
                default: prdata <= ZERO32;
            endcase
        end
    end

    assign irq = |(irq_reg & mask_reg);
    assign link.power_down_pin = ctrl_reg[B_PD];
    assign link.startup_trim_delay_select = ctrl_reg[B_DLYSEL];
    assign link.input_range_select = ctrl_reg[B_RANGE];
    assign link.demux_mode = ctrl_reg[B_DEMUX];
    assign link.reduced_level = ctrl_reg[B_REDUCED];
    assign link.phase_adjust_en = ctrl_reg[B_PHADJ];
    assign link.phase_trim_permit = ctrl_reg[B_PERMIT];
    assign link.cal_bit = ctrl_reg[B_CALBIT];
    assign link.trim_req_n = ctrl_reg[B_TRIMREQ]; // RL2
    wire unused_rd = rd;
endmodule

// [conv_link_props.sv]
// Concurrent checks on the link between converter and host ends
`timescale 1ns/100ps
module conv_link_props #(
    parameter logic [31:0] CAL_CYCLES = 32'h0000_001e
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic power_down_pin,
    input wire logic demux_mode,
    input wire logic phase_adjust_en,
    input wire logic phase_trim_permit,
    input wire logic cal_bit,
    input wire logic link_clk,
    input wire logic calibrating,
    input wire logic range_exceed,
    input wire logic [7:0] chan_a_bus,
    input wire logic [7:0] chan_b_bus,
    input wire logic [7:0] chan_a_delayed_bus,
    input wire logic [7:0] chan_b_delayed_bus
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [31:0] cal_len;
    logic [4:0] nd_cnt;
    logic cal_seen;
    // Length of the running calibration
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) cal_len <= 32'h0;
        else if (calibrating) cal_len <= cal_len + 32'h1;
        else cal_len <= 32'h0;
    end
    // Cycles in non-demux mode, saturating so the pipeline has flushed
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) nd_cnt <= 5'h0;
        else if (demux_mode) nd_cnt <= 5'h0;
        else if (nd_cnt != 5'h1f) nd_cnt <= nd_cnt + 5'h1;
    end
    // Idle known only once a calibration ended; pin commands are not tracked
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) cal_seen <= 1'b0;
        else if (!calibrating && cal_len != 32'h0) cal_seen <= 1'b1;
    end
    sequence half_step;
        $stable(link_clk) ##1 $changed(link_clk);
    endsequence
    sequence pd_held;
        power_down_pin [*4];
    endsequence
    chk_pd_stops_cal: assert property (pd_held |-> !calibrating)
        else $error("calibration active in power-down");
    chk_cal_length: assert property ($fell(calibrating) && !$past(power_down_pin, 1)
        && !$past(power_down_pin, 2) && !$past(power_down_pin, 3) |-> cal_len == CAL_CYCLES)
        else $error("calibration length wrong");
    chk_bus_half_rate: assert property (demux_mode [*6] ##0 $changed(chan_a_bus) |=> $stable(chan_a_bus))
        else $error("demux bus changed on consecutive clocks");
    chk_delayed_bus_idle: assert property (nd_cnt == 5'h1f |->
        chan_a_delayed_bus == 8'h00 && chan_b_delayed_bus == 8'h00)
        else $error("delayed bus active in non-demux mode");
    chk_link_clk_full: assert property (!demux_mode [*6] |-> ##1 $changed(link_clk))
        else $error("link clock not toggling each clock");
    chk_link_clk_half: assert property (demux_mode [*6] ##0 $changed(link_clk) |=> half_step)
        else $error("link clock not at half rate");
    chk_exceed_code: assert property (range_exceed && nd_cnt == 5'h1f |-> chan_a_bus == 8'h00
        || chan_a_bus == 8'hff || chan_b_bus == 8'h00 || chan_b_bus == 8'hff)
        else $error("range flag without saturated code");
    chk_skip_cal: assert property ($rose(cal_bit) && phase_adjust_en && !phase_trim_permit
        && !calibrating |=> !calibrating [*6])
        else $error("calibration ran without permit");
    chk_start_cal: assert property (cal_seen && !calibrating && !power_down_pin && $rose(cal_bit)
        && (!phase_adjust_en || phase_trim_permit) |-> ##[1:5] calibrating)
        else $error("requested calibration did not start");
endmodule

// [tb_top.sv]
// Self-checking bench joining converter end and host end
`timescale 1ns/100ps
module tb_top;
    import conv_ctrl_pkg::*;
    localparam logic [31:0] CAL_N = 32'h0000_001e;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, reduced_drive, busy, perr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata, v;
    logic signed [9:0] sample_a, sample_b;
    int miscompares, checked, n, d, ea, eb;
    int tv[8][2] = '{'{-200, 0}, '{-128, 5}, '{0, 127}, '{127, 200},
        '{300, -300}, '{5, -129}, '{-1, 1}, '{64, -64}};
    conv_link_if link ();
    conv_device #(.DELAY_SHORT(32'h14), .DELAY_LONG(32'h28), .CAL_CYCLES(CAL_N)) conv_device_i (
        .clk(clk), .reset_n(reset_n), .link(link), .sample_a(sample_a), .sample_b(sample_b),
        .reduced_drive(reduced_drive), .busy(busy));
    conv_host conv_host_i (.clk(clk), .reset_n(reset_n), .link(link), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));
    conv_link_props #(.CAL_CYCLES(CAL_N)) conv_link_props_i (.clk(clk), .reset_n(reset_n),
        .power_down_pin(link.power_down_pin), .demux_mode(link.demux_mode),
        .phase_adjust_en(link.phase_adjust_en), .phase_trim_permit(link.phase_trim_permit),
        .cal_bit(link.cal_bit), .link_clk(link.link_clk), .calibrating(link.calibrating),
        .range_exceed(link.range_exceed), .chan_a_bus(link.chan_a_bus),
        .chan_b_bus(link.chan_b_bus), .chan_a_delayed_bus(link.chan_a_delayed_bus),
        .chan_b_delayed_bus(link.chan_b_delayed_bus));
    // Free-running sample clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits on pready as long as it takes, the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rdata = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        chk(rdata & m, exp);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wait_busy(input int lim, output int cnt);
        cnt = 0;
        while (busy !== 1'b1 && cnt < lim) begin
            @(posedge clk);
            cnt++;
        end
    endtask
    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
    endtask
    task automatic complete_run();
        $display("Counts: %0d checked, %0d miscompares", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Expected output code: saturate, then offset binary
    function automatic logic [7:0] code(input int s);
        if (s < -128) return 8'h00;
        if (s > 127) return 8'hff;
        return 8'(s) ^ 8'h80;
    endfunction
    // Watchdog, well beyond the expected run of about 3900 clocks
    initial begin
        #(40 * 30000);
        miscompares++;
        complete_run();
    end
    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {sample_a, sample_b, miscompares, checked} = '0;
        do_reset();
        rdc(OFS_CTRL, 32'h0000_0100, 32'hffff_ffff);
        rdc(OFS_STAT, 32'h0, 32'h3);
        rdc(8'h20, 32'h0, 32'hffff_ffff);
        chk({31'h0, perr}, 32'h1);
        $display("test registers done");
        // Startup delay, frozen by power-down, for both select levels
        for (int sel = 0; sel < 2; sel++) begin
            do_reset();
            wr_ctrl(32'h1 | (32'(sel) << B_DLYSEL));
            wait_busy(60, n);
            chk({31'h0, busy}, 32'h0);
            wr_ctrl(32'(sel) << B_DLYSEL);
            wait_busy(200, n);
            d = sel ? 40 : 20;
            chk({31'h0, busy}, 32'h1);
            chk(32'(n >= d - 8 && n <= d + 6), 32'h1);
            cyc(40);
            chk({31'h0, busy}, 32'h0);
            wr_ctrl(32'h100);
        end
        $display("test startup done");
        // Trim pin high at power-up: only a full pin command calibrates
        do_reset();
        wait_busy(100, n);
        chk({31'h0, busy}, 32'h0);
        wr_ctrl(32'h0);
        cyc(TRIM_LOW_MIN + 10);
        wr_ctrl(32'h100);
        cyc(TRIM_HIGH_MIN - 10);
        chk({31'h0, busy}, 32'h0);
        wait_busy(40, n);
        chk({31'h0, busy}, 32'h1);
        cyc(40);
        // Calibration-done interrupt: a set mask bit enables; enable, mask, clear
        apb(1'b1, OFS_MASK, 32'h1);
        cyc(1);
        chk({31'h0, irq}, 32'h1);
        rdc(OFS_IRQ, 32'h1, 32'h1);
        apb(1'b1, OFS_MASK, 32'h0);
        cyc(1);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, OFS_MASK, 32'h1);
        apb(1'b1, OFS_IRQ, 32'h1);
        cyc(1);
        chk({31'h0, irq}, 32'h0);
        $display("test trim pin done");
        // Calibration bit over all phase adjust and permit settings
        for (int c = 0; c < 4; c++) begin
            v = 32'h100 | (32'(c) << B_PHADJ) | (32'h1 << B_CALBIT);
            wr_ctrl(v);
            cyc(10);
            chk({31'h0, busy}, 32'(c != 1));
            cyc(40);
            wr_ctrl(v);
            cyc(10);
            chk({31'h0, busy}, 32'h0);
            wr_ctrl(32'h100);
        end
        // Power-down aborts a calibration and blocks a new one
        wr_ctrl(32'h180);
        cyc(5);
        wr_ctrl(32'h181);
        cyc(8);
        chk({31'h0, busy}, 32'h0);
        wr_ctrl(32'h101);
        wr_ctrl(32'h181);
        cyc(10);
        chk({31'h0, busy}, 32'h0);
        wr_ctrl(32'h100);
        cyc(10);
        chk({31'h0, busy}, 32'h0);
        // Range select change and a calibration request in the same write
        wr_ctrl(32'h184);
        cyc(10);
        chk({31'h0, busy}, 32'h1);
        $display("test calibration bit done");
        // Codes, saturation and shared flag, in both bus modes
        for (int m = 0; m < 2; m++) begin
            wr_ctrl(32'h104 | (32'(m) << B_DEMUX) | (32'(m) << B_REDUCED));
            for (int i = 0; i < 8; i++) begin
                @(posedge clk);
                sample_a <= 10'(tv[i][0]);
                sample_b <= 10'(tv[i][1]);
                ea = tv[i][0];
                eb = tv[i][1];
                cyc(20);
                chk({24'h0, link.chan_a_bus}, {24'h0, code(ea)});
                chk({24'h0, link.chan_b_bus}, {24'h0, code(eb)});
                v = 32'(ea < -128 || ea > 127 || eb < -128 || eb > 127);
                chk({31'h0, link.range_exceed}, v);
                chk({24'h0, link.chan_a_delayed_bus}, m ? {24'h0, code(ea)} : 32'h0);
                chk({24'h0, link.chan_b_delayed_bus}, m ? {24'h0, code(eb)} : 32'h0);
                chk({31'h0, reduced_drive}, 32'(m));
                rdc(OFS_STAT, v << 1, 32'h2);
                v = {m ? {code(eb), code(ea)} : 16'h0, code(eb), code(ea)};
                rdc(OFS_DATA, v, ~ZERO32);
            end
        end
        $display("test output codes done");
        // Latency of the primary bus from a single step
        wr_ctrl(32'h104);
        @(posedge clk);
        sample_a <= 10'sd3;
        cyc(20);
        @(posedge clk);
        sample_a <= 10'sd40;
        cyc(13);
        chk({24'h0, link.chan_a_bus}, {24'h0, code(3)});
        cyc(1);
        chk({24'h0, link.chan_a_bus}, {24'h0, code(40)});
        $display("test latency done");
        complete_run();
    end
    task automatic wr_ctrl(input logic [31:0] val);
        apb(1'b1, OFS_CTRL, val);
    endtask
endmodule
